// *** dv/lclf_handler_assertions.sv ***
// port checker for the lock fault handler
// assumes full-word register writes from the bus master
`timescale 1ns/1ps
module lclf_handler_assertions #(
  parameter int unsigned P_TICK_CYCLES = lclf_pkg::TICK_CYCLES
) (
  input wire logic        i_sys_clk,
  input wire logic        i_resetn,
  input wire logic [7:0]  i_address,
  input wire logic        i_read,
  input wire logic        i_write,
  input wire logic [31:0] i_writedata,
  input wire logic        o_waitrequest,
  input wire logic        i_current_limit,
  input wire logic        o_fault_indicator_n,
  input wire logic [2:0]  o_drive_mode
);
  logic [3:0]  act_q;
  logic [3:0]  deg_q;
  logic [11:0] ms_q;
  logic [31:0] hi_cnt;
  logic [31:0] lo_cnt;
  logic [31:0] min_c;
  logic [31:0] max_c;
  logic [31:0] ivl_c;
  logic        acc;
  logic        cmd_w;
  logic        rty;
  assign acc   = i_write && !o_waitrequest;
  assign cmd_w = acc && i_address == lclf_pkg::OFS_CMD;
  assign rty   = act_q inside {[4'h4:4'h7]};
  always_comb begin
    min_c = P_TICK_CYCLES * (lclf_pkg::DEG_US[(deg_q == 4'hF) ? 4'hE : deg_q]
            / lclf_pkg::TICK_US - 1);
    max_c = min_c + 2 * P_TICK_CYCLES + 4;
    ivl_c = 32'(ms_q) * 100 * P_TICK_CYCLES;
  end
  // shadow of the configuration and run lengths of the pins
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      act_q  <= lclf_pkg::RST_ACT;
      deg_q  <= lclf_pkg::RST_DEG;
      ms_q   <= lclf_pkg::RST_RTY_MS;
      hi_cnt <= '0;
      lo_cnt <= '0;
    end else begin
      if (acc && i_address == lclf_pkg::OFS_CFG) begin
        act_q <= i_writedata[10:7];
        deg_q <= i_writedata[14:11];
      end
      if (acc && i_address == lclf_pkg::OFS_RETRY) begin
        ms_q <= i_writedata[11:0];
      end
      hi_cnt <= i_current_limit ? hi_cnt + 1 : '0;
      lo_cnt <= o_fault_indicator_n ? '0 : lo_cnt + 1;
    end
  end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  sequence s_req;
    (i_read || i_write) && o_waitrequest;
  endsequence
  sequence s_ans;
    !o_waitrequest ##1 o_waitrequest;
  endsequence
  sequence s_onset;
    $fell(o_fault_indicator_n);
  endsequence
  property p_mode(logic [3:0] c, logic [2:0] m);
    s_onset ##0 act_q == c |-> o_drive_mode == m;
  endproperty
  a_bus_one_wait: assert property (s_req |=> s_ans)
    else $error("bus answer not after one wait cycle");
  a_hiz_mode: assert property (p_mode(4'h4, 3'h1))
    else $error("fault without hi-z outputs");
  a_recirc_mode: assert property (p_mode(4'h5, 3'h2))
    else $error("fault without recirculation");
  a_hs_brake: assert property (p_mode(4'h6, 3'h3))
    else $error("fault without high-side brake");
  a_ls_brake: assert property (p_mode(4'h7, 3'h4))
    else $error("fault without low-side brake");
  a_report_keeps: assert property (
    act_q == 4'h8 && $past(act_q, 2) == 4'h8 |-> o_drive_mode == 3'h0)
    else $error("report mode changed the output stage");
  a_off_quiet: assert property (
    act_q >= 4'h9 && $past(act_q, 3) >= 4'h9
    |-> o_fault_indicator_n && o_drive_mode == 3'h0)
    else $error("disabled detection still acts");
  a_deglitch_min: assert property (
    s_onset ##0 act_q inside {[4'h4:4'h8]} |-> hi_cnt >= min_c)
    else $error("fault before the deglitch time");
  a_deglitch_max: assert property (
    act_q inside {[4'h4:4'h8]} && hi_cnt == max_c |-> !o_fault_indicator_n)
    else $error("no fault after the deglitch time");
  a_hold_interval: assert property (
    $rose(o_fault_indicator_n) && rty && $past(act_q, 3) == act_q
    && !$past(cmd_w) && !$past(cmd_w, 2) |-> lo_cnt + 2 >= ivl_c)
    else $error("fault cleared before the retry interval");
endmodule
bind lclf_handler lclf_handler_assertions #(
  .P_TICK_CYCLES(P_TICK_CYCLES)
) u_lclf_chk (
  .i_sys_clk          (i_sys_clk),
  .i_resetn           (i_resetn),
  .i_address          (i_address),
  .i_read             (i_read),
  .i_write            (i_write),
  .i_writedata        (i_writedata),
  .o_waitrequest      (o_waitrequest),
  .i_current_limit    (i_current_limit),
  .o_fault_indicator_n(o_fault_indicator_n),
  .o_drive_mode       (o_drive_mode)
);

// *** dv/lclf_handler_tb_top.sv ***
// self-checking bench for the lock fault handler
// assumes the stage model closes the current-limit loop
`timescale 1ns/1ps
module lclf_handler_tb_top;
  localparam int unsigned P = 2;
  logic        i_sys_clk = 1'b0;
  logic        i_resetn = 1'b0;
  logic [7:0]  i_address = 8'h00;
  logic        i_read = 1'b0;
  logic        i_write = 1'b0;
  logic [31:0] i_writedata = 32'h0;
  logic [3:0]  i_byteenable = 4'hF;
  logic        locked = 1'b0;
  logic [31:0] o_readdata;
  logic        o_waitrequest;
  logic        cur_lim;
  logic        o_fault_indicator_n;
  logic [2:0]  o_drive_mode;
  logic        o_irq;
  logic [31:0] q;
  int          mismatches = 0;
  int          check_count = 0;
  int          cycles = 0;
  always #20 i_sys_clk = ~i_sys_clk;
  lclf_handler #(.P_TICK_CYCLES(P)) dut (
    .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_address(i_address),
    .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
    .i_byteenable(i_byteenable), .o_readdata(o_readdata),
    .o_waitrequest(o_waitrequest), .i_current_limit(cur_lim),
    .o_fault_indicator_n(o_fault_indicator_n),
    .o_drive_mode(o_drive_mode), .o_irq(o_irq));
  lclf_stage_model u_stage (.i_sys_clk(i_sys_clk), .i_locked(locked),
    .i_drive_mode(o_drive_mode), .o_current_limit(cur_lim));
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge i_sys_clk);
    i_address <= a;
    i_writedata <= d;
    i_write <= w;
    i_read <= !w;
    do @(posedge i_sys_clk); while (o_waitrequest !== 1'b0);
    q = o_readdata;
    i_write <= 1'b0;
    i_read <= 1'b0;
  endtask
  task automatic wait_flag(input logic v, output int n);
    n = 0;
    while (o_fault_indicator_n !== v && n < 200000) begin
      @(posedge i_sys_clk);
      n++;
    end
  endtask
  task automatic t_reset();
    bus(1'b0, lclf_pkg::OFS_CFG, 32'h0);
    chk(q, 32'h0000_0480);
    bus(1'b0, lclf_pkg::OFS_RETRY, 32'h0);
    chk(q, 32'h0003_0064);
    bus(1'b0, 8'h18, 32'h0);
    chk(q, 32'h0);
    chk(32'({o_fault_indicator_n, o_drive_mode, o_irq}), 32'h10);
    $display("reset test done");
  endtask
  task automatic t_off();
    for (int c = 0; c < 16; c++) begin
      if (c > 3 && c < 9) continue;
      bus(1'b1, lclf_pkg::OFS_CFG, 32'(c) << 7);
      locked <= 1'b1;
      repeat (40) @(posedge i_sys_clk);
      chk(32'({o_fault_indicator_n, o_drive_mode, o_irq}), 32'h10);
      locked <= 1'b0;
    end
    bus(1'b0, lclf_pkg::OFS_IRQS, 32'h0);
    chk(q, 32'h0);
    $display("disabled codes test done");
  endtask
  task automatic t_deglitch();
    int n;
    int t;
    for (int c = 0; c < 11; c++) begin
      bus(1'b1, lclf_pkg::OFS_CFG, 32'h400 | (32'(c) << 11));
      locked <= 1'b1;
      wait_flag(1'b0, n);
      t = lclf_pkg::DEG_US[c] / lclf_pkg::TICK_US;
      chk(32'(n >= P * (t - 1) && n <= P * t + P + 4), 32'h1);
      chk(32'(o_drive_mode), 32'h0);
      chk(32'(o_irq), 32'h0);
      locked <= 1'b0;
      repeat (6) @(posedge i_sys_clk);
      chk(32'(o_fault_indicator_n), 32'h1);
    end
    bus(1'b0, lclf_pkg::OFS_IRQS, 32'h0);
    $display("deglitch test done");
  endtask
  task automatic t_glitch_irq();
    int n;
    bus(1'b1, lclf_pkg::OFS_IRQM, 32'h1);
    bus(1'b1, lclf_pkg::OFS_CFG, 32'h0000_1C00);
    locked <= 1'b1;
    repeat (80) @(posedge i_sys_clk);
    locked <= 1'b0;
    repeat (3) @(posedge i_sys_clk);
    chk(32'(o_fault_indicator_n), 32'h1);
    locked <= 1'b1;
    wait_flag(1'b0, n);
    chk(32'(n >= 98), 32'h1);
    repeat (3) @(posedge i_sys_clk);
    chk(32'(o_irq), 32'h1);
    bus(1'b0, lclf_pkg::OFS_IRQS, 32'h0);
    chk(q & 32'h1, 32'h1);
    repeat (3) @(posedge i_sys_clk);
    chk(32'(o_irq), 32'h0);
    locked <= 1'b0;
    bus(1'b1, lclf_pkg::OFS_IRQM, 32'h0);
    $display("restart and interrupt test done");
  endtask
  task automatic t_retry(input logic [3:0] code, input logic [2:0] mode);
    int n;
    bus(1'b1, lclf_pkg::OFS_CMD, 32'h1);
    bus(1'b1, lclf_pkg::OFS_RETRY, 32'h0001_0001);
    bus(1'b1, lclf_pkg::OFS_CFG, 32'(code) << 7);
    bus(1'b0, lclf_pkg::OFS_IRQS, 32'h0);
    locked <= 1'b1;
    wait_flag(1'b0, n);
    chk(32'(o_drive_mode), 32'(mode));
    wait_flag(1'b1, n);
    chk(32'(n >= 196 && n <= 206), 32'h1);
    wait_flag(1'b0, n);
    repeat (220) @(posedge i_sys_clk);
    chk(32'({o_fault_indicator_n, o_drive_mode}), 32'(mode));
    bus(1'b0, lclf_pkg::OFS_STAT, 32'h0);
    chk(32'(q[1]), 32'h1);
    locked <= 1'b0;
    bus(1'b1, lclf_pkg::OFS_CMD, 32'h1);
    repeat (3) @(posedge i_sys_clk);
    chk(32'({o_fault_indicator_n, o_drive_mode}), 32'h8);
    bus(1'b0, lclf_pkg::OFS_IRQS, 32'h0);
    chk(q & 32'h7, 32'h7);
    $display("retry test done for code %h", code);
  endtask
  initial begin
    repeat (16) @(posedge i_sys_clk);
    i_resetn <= 1'b1;
    t_reset();
    t_off();
    t_deglitch();
    t_glitch_irq();
    t_retry(4'h4, 3'h1);
    t_retry(4'h5, 3'h2);
    t_retry(4'h6, 3'h3);
    t_retry(4'h7, 3'h4);
    finish_test();
  end
  // cut a hang short
  always @(posedge i_sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      mismatches++;
      finish_test();
    end
  end
endmodule

// *** dv/lclf_stage_model.sv ***
// output stage model: a stalled rotor hits current limit while driven
// assumes drive mode codes of the package, one clock
`timescale 1ns/1ps
module lclf_stage_model (
  // clock
  input  wire logic       i_sys_clk,
  // rotor state and block outputs
  input  wire logic       i_locked,
  input  wire logic [2:0] i_drive_mode,
  // current-limit condition
  output logic            o_current_limit = 1'b0
);
  // any braking or hi-z state removes the limit current
  always @(posedge i_sys_clk) begin
    o_current_limit <= i_locked && i_drive_mode == lclf_pkg::DRV_NORMAL;
  end
endmodule

// *** include/lclf_pkg.sv ***
// constants and types of the current-limit lock fault handler
// assumes one 25 MHz clock and a 32-bit Avalon-MM register port
package lclf_pkg;
  // timing
  localparam int unsigned CLK_HZ       = 25_000_000;
  localparam int unsigned TICK_US      = 10;
  localparam int unsigned TICK_CYCLES  = CLK_HZ / 1_000_000 * TICK_US;
  localparam int unsigned TICKS_PER_MS = 1000 / TICK_US;
  localparam int unsigned TICK_W       = 16;
  localparam int unsigned RTMR_W       = 20;
  // deglitch times in microseconds, index is the code
  localparam int unsigned DEG_US [15] = '{
    50, 100, 200, 500, 1000, 2500, 5000, 7500,
    10000, 25000, 50000, 75000, 100000, 200000, 500000};
  // register byte offsets
  localparam logic [7:0] OFS_CFG   = 8'h00;
  localparam logic [7:0] OFS_RETRY = 8'h04;
  localparam logic [7:0] OFS_STAT  = 8'h08;
  localparam logic [7:0] OFS_IRQS  = 8'h0C;
  localparam logic [7:0] OFS_IRQM  = 8'h10;
  localparam logic [7:0] OFS_CMD   = 8'h14;
  // field positions
  localparam int unsigned CFG_ACT_LSB = 7;
  localparam int unsigned CFG_DEG_LSB = 11;
  localparam int unsigned RTY_MS_LSB  = 0;
  localparam int unsigned RTY_MS_W    = 12;
  localparam int unsigned RTY_CNT_LSB = 16;
  localparam int unsigned STAT_FAULT  = 0;
  localparam int unsigned STAT_LATCH  = 1;
  localparam int unsigned STAT_QUAL   = 2;
  localparam int unsigned STAT_DRV    = 4;
  localparam int unsigned STAT_USED   = 8;
  localparam int unsigned CMD_CLR     = 0;
  localparam int unsigned IRQ_EVT     = 0;
  localparam int unsigned IRQ_RETRY   = 1;
  localparam int unsigned IRQ_LATCH   = 2;
  localparam int unsigned IRQ_W       = 3;
  // reset values
  localparam logic [3:0]  RST_ACT    = 4'h9;
  localparam logic [3:0]  RST_DEG    = 4'h0;
  localparam logic [11:0] RST_RTY_MS = 12'h064;
  localparam logic [3:0]  RST_RTY_N  = 4'h3;
  // action codes
  localparam logic [3:0] ACT_HIZ    = 4'h4;
  localparam logic [3:0] ACT_RECIRC = 4'h5;
  localparam logic [3:0] ACT_HSB    = 4'h6;
  localparam logic [3:0] ACT_LSB    = 4'h7;
  localparam logic [3:0] ACT_REPORT = 4'h8;

  typedef enum logic [2:0] {
    DRV_NORMAL   = 3'h0,
    DRV_HIZ      = 3'h1,
    DRV_RECIRC   = 3'h2,
    DRV_HS_BRAKE = 3'h3,
    DRV_LS_BRAKE = 3'h4
  } lclf_drive_e;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_RETRY  = 4'b0010,
    ST_LATCH  = 4'b0100,
    ST_REPORT = 4'b1000
  } lclf_state_e;
endpackage

// *** include/lclf_qual_if.sv ***
// carrier between the fault handler and its deglitch qualifier
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface lclf_qual_if;
  logic                           tick;
  logic                           cond;
  logic                           enable;
  logic                           restart;
  logic [lclf_pkg::TICK_W-1:0]    limit;
  logic                           evt;
  logic                           qualified;
  modport ctl (output tick, cond, enable, restart, limit,
               input evt, qualified);
  modport qual (input tick, cond, enable, restart, limit,
                output evt, qualified);
endinterface

// *** rtl/lclf_handler.sv ***
// current-limit lock fault handler with Avalon-MM register slave
// assumes current-limit flag synchronous to i_sys_clk
`timescale 1ns/1ps
module lclf_handler #(
  parameter int unsigned P_TICK_CYCLES = lclf_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_resetn,
  // avalon-mm slave
  input  wire logic [7:0]  i_address,
  input  wire logic        i_read,
  input  wire logic        i_write,
  input  wire logic [31:0] i_writedata,
  input  wire logic [3:0]  i_byteenable,
  output logic [31:0]      o_readdata,
  output logic             o_waitrequest,
  // current-limit condition
  input  wire logic        i_current_limit,
  // fault outputs
  output logic             o_fault_indicator_n,
  output logic [2:0]       o_drive_mode,
  output logic             o_irq
);
  localparam int unsigned PW = 12;

  // byte-lane merge of a write into a register
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return r;
  endfunction

  // codes that run the retry sequence
  function automatic logic is_retry(input logic [3:0] a);
    return (a >= lclf_pkg::ACT_HIZ) && (a <= lclf_pkg::ACT_LSB);
  endfunction

  // codes for which detection runs at all
  function automatic logic is_on(input logic [3:0] a);
    return is_retry(a) || (a == lclf_pkg::ACT_REPORT);
  endfunction

  // output-stage state for a retry code
  function automatic lclf_pkg::lclf_drive_e drv_of(input logic [3:0] a);
    case (a)
      lclf_pkg::ACT_HIZ:    return lclf_pkg::DRV_HIZ;
      lclf_pkg::ACT_RECIRC: return lclf_pkg::DRV_RECIRC;
      lclf_pkg::ACT_HSB:    return lclf_pkg::DRV_HS_BRAKE;
      lclf_pkg::ACT_LSB:    return lclf_pkg::DRV_LS_BRAKE;
      default:              return lclf_pkg::DRV_NORMAL;
    endcase
  endfunction

  // deglitch code to ticks
  function automatic logic [lclf_pkg::TICK_W-1:0] deg_ticks(
      input logic [3:0] c);
    int unsigned us;
    us = (c == 4'hF) ? lclf_pkg::DEG_US[14] : lclf_pkg::DEG_US[c];
    return lclf_pkg::TICK_W'(us / lclf_pkg::TICK_US);
  endfunction

  lclf_qual_if qif ();

  lclf_qualify u_qual (
    .i_sys_clk (i_sys_clk),
    .i_resetn  (i_resetn),
    .q         (qif.qual)
  );

  // ---------------- register bus ----------------
  logic [3:0]             act_reg;
  logic [3:0]             act_next;
  logic [3:0]             deg_reg;
  logic [3:0]             deg_next;
  logic [11:0]            rms_reg;
  logic [11:0]            rms_next;
  logic [3:0]             rcnt_reg;
  logic [3:0]             rcnt_next;
  logic [lclf_pkg::IRQ_W-1:0] mask_reg;
  logic [lclf_pkg::IRQ_W-1:0] mask_next;
  logic [31:0]            rdata_reg;
  logic [31:0]            rdata_next;
  logic                   wait_reg;
  logic                   wait_next;
  logic                   accept;
  logic                   done_wr;
  logic                   done_rd;
  logic                   clr_cmd;
  logic [31:0]            cfg_word;
  logic [31:0]            rty_word;
  logic [31:0]            stat_word;
  logic [31:0]            w_cfg;
  logic [31:0]            w_rty;
  logic [31:0]            w_msk;

  // state of the fault sequence, declared early for the read mux
  lclf_pkg::lclf_state_e  st_reg;
  lclf_pkg::lclf_state_e  st_next;
  logic [2:0]             drv_reg;
  logic [2:0]             drv_next;
  logic                   fault_n_reg;
  logic                   fault_n_next;
  logic [3:0]             used_reg;
  logic [3:0]             used_next;
  logic [lclf_pkg::RTMR_W-1:0] rtmr_reg;
  logic [lclf_pkg::RTMR_W-1:0] rtmr_next;
  logic [lclf_pkg::IRQ_W-1:0]  irqs_reg;
  logic [lclf_pkg::IRQ_W-1:0]  irqs_next;
  logic [lclf_pkg::IRQ_W-1:0]  irq_set;
  logic                   irq_reg;
  logic                   irq_next;
  logic                   restart;

  // one wait cycle, then the request completes
  assign accept  = (i_read || i_write) && wait_reg;
  assign done_wr = i_write && !wait_reg;
  assign done_rd = i_read && !wait_reg;
  assign clr_cmd = done_wr && (i_address == lclf_pkg::OFS_CMD)
                   && i_byteenable[0]
                   && i_writedata[lclf_pkg::CMD_CLR];

  always_comb begin
    cfg_word = '0;
    cfg_word[lclf_pkg::CFG_ACT_LSB +: 4] = act_reg;
    cfg_word[lclf_pkg::CFG_DEG_LSB +: 4] = deg_reg;
    rty_word = '0;
    rty_word[lclf_pkg::RTY_MS_LSB +: lclf_pkg::RTY_MS_W] = rms_reg;
    rty_word[lclf_pkg::RTY_CNT_LSB +: 4] = rcnt_reg;
    stat_word = '0;
    stat_word[lclf_pkg::STAT_FAULT] = !fault_n_reg;
    stat_word[lclf_pkg::STAT_LATCH] = (st_reg == lclf_pkg::ST_LATCH);
    stat_word[lclf_pkg::STAT_QUAL]  = qif.qualified;
    stat_word[lclf_pkg::STAT_DRV +: 3]  = drv_reg;
    stat_word[lclf_pkg::STAT_USED +: 4] = used_reg;
  end

  always_comb begin
    w_cfg     = merge(cfg_word, i_writedata, i_byteenable);
    w_rty     = merge(rty_word, i_writedata, i_byteenable);
    w_msk     = merge(32'(mask_reg), i_writedata, i_byteenable);
    act_next  = act_reg;
    deg_next  = deg_reg;
    rms_next  = rms_reg;
    rcnt_next = rcnt_reg;
    mask_next = mask_reg;
    wait_next = !accept;
    rdata_next = rdata_reg;
    if (done_wr) begin
      case (i_address)
        lclf_pkg::OFS_CFG: begin
          act_next = w_cfg[lclf_pkg::CFG_ACT_LSB +: 4];
          deg_next = w_cfg[lclf_pkg::CFG_DEG_LSB +: 4];
        end
        lclf_pkg::OFS_RETRY: begin
          rms_next  = w_rty[lclf_pkg::RTY_MS_LSB +: lclf_pkg::RTY_MS_W];
          rcnt_next = w_rty[lclf_pkg::RTY_CNT_LSB +: 4];
        end
        lclf_pkg::OFS_IRQM: mask_next = w_msk[lclf_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end
    if (accept) begin
      case (i_address)
        lclf_pkg::OFS_CFG:   rdata_next = cfg_word;
        lclf_pkg::OFS_RETRY: rdata_next = rty_word;
        lclf_pkg::OFS_STAT:  rdata_next = stat_word;
        lclf_pkg::OFS_IRQS:  rdata_next = 32'(irqs_reg);
        lclf_pkg::OFS_IRQM:  rdata_next = 32'(mask_reg);
        default:             rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      act_reg   <= lclf_pkg::RST_ACT;
      deg_reg   <= lclf_pkg::RST_DEG;
      rms_reg   <= lclf_pkg::RST_RTY_MS;
      rcnt_reg  <= lclf_pkg::RST_RTY_N;
      mask_reg  <= '0;
      wait_reg  <= 1'b1;
      rdata_reg <= '0;
    end else begin
      act_reg   <= act_next;
      deg_reg   <= deg_next;
      rms_reg   <= rms_next;
      rcnt_reg  <= rcnt_next;
      mask_reg  <= mask_next;
      wait_reg  <= wait_next;
      rdata_reg <= rdata_next;
    end
  end

  // ---------------- tick prescaler ----------------
  logic [PW-1:0] pre_reg;
  logic [PW-1:0] pre_next;
  logic          tick_reg;
  logic          tick_next;

  always_comb begin
    tick_next = (pre_reg == PW'(P_TICK_CYCLES - 1));
    pre_next  = tick_next ? '0 : pre_reg + 1'b1;
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pre_reg  <= '0;
      tick_reg <= 1'b0;
    end else begin
      pre_reg  <= pre_next;
      tick_reg <= tick_next;
    end
  end

  assign qif.tick    = tick_reg;
  assign qif.cond    = i_current_limit;
  assign qif.enable  = is_on(act_reg);
  assign qif.restart = restart;
  assign qif.limit   = deg_ticks(deg_reg);

  // ---------------- fault sequence ----------------
  logic [lclf_pkg::RTMR_W-1:0] rty_ticks;
  assign rty_ticks = lclf_pkg::RTMR_W'(rms_reg)
                     * lclf_pkg::RTMR_W'(lclf_pkg::TICKS_PER_MS);

  always_comb begin
    st_next      = st_reg;
    drv_next     = drv_reg;
    fault_n_next = fault_n_reg;
    used_next    = used_reg;
    rtmr_next    = rtmr_reg;
    irq_set      = '0;
    restart      = 1'b0;
    if (!is_on(act_reg)) begin
      st_next      = lclf_pkg::ST_IDLE;
      drv_next     = lclf_pkg::DRV_NORMAL;
      fault_n_next = 1'b1;
    end else begin
      case (st_reg)
        lclf_pkg::ST_IDLE: begin
          if (qif.evt) begin
            irq_set[lclf_pkg::IRQ_EVT] = 1'b1;
            fault_n_next = 1'b0;
            if (act_reg == lclf_pkg::ACT_REPORT) begin
              st_next = lclf_pkg::ST_REPORT;
            end else begin
              st_next   = lclf_pkg::ST_RETRY;
              drv_next  = drv_of(act_reg);
              rtmr_next = '0;
            end
          end
        end
        lclf_pkg::ST_RETRY: begin
          if (rtmr_reg >= rty_ticks) begin
            if (used_reg < rcnt_reg) begin
              st_next      = lclf_pkg::ST_IDLE;
              used_next    = used_reg + 1'b1;
              drv_next     = lclf_pkg::DRV_NORMAL;
              fault_n_next = 1'b1;
              restart      = 1'b1;
              irq_set[lclf_pkg::IRQ_RETRY] = 1'b1;
            end else begin
              st_next = lclf_pkg::ST_LATCH;
              irq_set[lclf_pkg::IRQ_LATCH] = 1'b1;
            end
          end else if (tick_reg) begin
            rtmr_next = rtmr_reg + 1'b1;
          end
        end
        lclf_pkg::ST_LATCH: begin
          if (clr_cmd) begin
            st_next      = lclf_pkg::ST_IDLE;
            used_next    = '0;
            drv_next     = lclf_pkg::DRV_NORMAL;
            fault_n_next = 1'b1;
            restart      = 1'b1;
          end
        end
        lclf_pkg::ST_REPORT: begin
          if (!qif.qualified || act_reg != lclf_pkg::ACT_REPORT) begin
            st_next      = lclf_pkg::ST_IDLE;
            fault_n_next = 1'b1;
          end
        end
        default: begin
          st_next      = lclf_pkg::ST_IDLE;
          drv_next     = lclf_pkg::DRV_NORMAL;
          fault_n_next = 1'b1;
        end
      endcase
    end
    if (clr_cmd && st_reg != lclf_pkg::ST_LATCH) begin
      used_next = '0;
    end
  end

  // sticky status: a set in the clearing cycle survives
  always_comb begin
    irqs_next = irqs_reg;
    if (done_rd && i_address == lclf_pkg::OFS_IRQS) begin
      irqs_next = '0;
    end
    irqs_next = irqs_next | irq_set;
    irq_next  = |(irqs_reg & mask_reg);
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_reg      <= lclf_pkg::ST_IDLE;
      drv_reg     <= lclf_pkg::DRV_NORMAL;
      fault_n_reg <= 1'b1;
      used_reg    <= '0;
      rtmr_reg    <= '0;
      irqs_reg    <= '0;
      irq_reg     <= 1'b0;
    end else begin
      st_reg      <= st_next;
      drv_reg     <= drv_next;
      fault_n_reg <= fault_n_next;
      used_reg    <= used_next;
      rtmr_reg    <= rtmr_next;
      irqs_reg    <= irqs_next;
      irq_reg     <= irq_next;
    end
  end

  assign o_readdata          = rdata_reg;
  assign o_waitrequest       = wait_reg;
  assign o_fault_indicator_n = fault_n_reg;
  assign o_drive_mode        = drv_reg;
  assign o_irq               = irq_reg;
endmodule

// *** rtl/lclf_qualify.sv ***
// deglitch qualifier: counts ticks of an unbroken condition
// assumes tick is a one-cycle pulse from the handler's prescaler
`timescale 1ns/1ps
module lclf_qualify (
  // clock and reset
  input  wire logic   i_sys_clk,
  input  wire logic   i_resetn,
  // handler side
  lclf_qual_if.qual   q
);
  logic [lclf_pkg::TICK_W-1:0] cnt_reg;
  logic [lclf_pkg::TICK_W-1:0] cnt_next;
  logic                        done_reg;
  logic                        done_next;
  logic                        evt_reg;
  logic                        evt_next;

  always_comb begin
    cnt_next  = cnt_reg;
    done_next = done_reg;
    evt_next  = 1'b0;
    if (!q.enable || !q.cond || q.restart) begin
      cnt_next  = '0;
      done_next = 1'b0;
    end else if (q.tick && !done_reg) begin
      if (cnt_reg + 1'b1 >= q.limit) begin
        done_next = 1'b1;
        evt_next  = 1'b1;
      end else begin
        cnt_next = cnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_reg  <= '0;
      done_reg <= 1'b0;
      evt_reg  <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      done_reg <= done_next;
      evt_reg  <= evt_next;
    end
  end

  assign q.evt       = evt_reg;
  assign q.qualified = done_reg;
endmodule
